// ==== hdl/hp_host_port.sv ====
// Serial host port: SPI slave and I2C slave sharing the pins
// How it works
// RULE_01: Select pin high means I2C with SPI in reset; low means SPI.
// RULE_02: I2C answers 0xD4/0xD5 with id pin 0, 0xD6/0xD7 with 1.
// RULE_03: Writing 1 to bit 7 of register 0x11 turns I2C off.
// RULE_04: SPI output floats except in the read data phase.
// RULE_05: SPI samples on rising clock, shifts out on falling clock.
// RULE_06: SPI word frame is address, command, data over 24 clocks.
// RULE_07: SPI write happens on rising edge 24; later bits ignored.
// RULE_08: Host raises and lowers chip select between writes.
// RULE_09: Chip select rising before edge 24 aborts the access.
// RULE_10: Read fetched at edge 16, MSB out on next falling edge.
// RULE_11: Normal read ignores edges past 24 and sends zeros.
// RULE_12: Host reads FIFO only by burst, ideally draining it all.
// RULE_13: Burst read streams FIFO words, 24 clocks each, after 16.
// RULE_14: FIFO word is 4-bit tag then 20 data bits, MSB first.
// RULE_15: I2C works with master clock up to 400 kHz.
// RULE_16: I2C write is slave address, register address, data bytes.
// RULE_17: Register pointer steps by one after each data byte.
// RULE_18: Data line is open drain only; clock line only input.
// RULE_19: One bit per clock; data steady while clock high.
// RULE_20: Data falling with clock high is START, rising is STOP.
// RULE_21: Repeated START acts like START and keeps the bus busy.
// RULE_22: STOP honoured anywhere except in the START's clock pulse.
// RULE_23: Device holds data low through the ninth clock after a byte.
// RULE_24: Master acks every read byte but the last, then STOP.
// RULE_25: SPI command 0x00 writes, 0x80 reads; FIFO address bursts.
module hp_host_port import hp_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_chip_select_low,
  input wire logic i_sclk,
  input wire logic i_sdi_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_sdo_addr,
  output logic o_sdo,
  output logic o_sdo_oe,
  output hp_reg_req_s o_reg,
  input wire logic [7:0] i_reg_rdata,
  output logic o_fifo_pop,
  input wire hp_fifo_word_s i_fifo_word
);
`include "hp_consts.svh"
  hp_state_s st_reg;
  hp_state_s st_next;
  logic [3:0] pins;
  logic cs_s;
  logic clk_s;
  logic dat_s;
  logic id_s;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic i2c_mode;
  logic [7:0] my_addr;
  logic [7:0] s_byte;
  logic [7:0] i_byte;
  logic [5:0] s_cnt_n;
  logic s_read;
  logic s_burst;
  logic i_rx;

  // Both serial modes are far slower than the system clock
  hp_sync u_sync ( // RULE_15
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async({i_sdo_addr, i_sdi_sda, i_sclk, i_chip_select_low}),
    .o_sync(pins)
  );

  assign cs_s = pins[0];
  assign clk_s = pins[1];
  assign dat_s = pins[2];
  assign id_s = pins[3];

  hp_bus_cond u_cond (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_scl(clk_s),
    .i_sda(dat_s),
    .o_rise(rise),
    .o_fall(fall),
    .o_start(start),
    .o_stop(stop)
  );

  function automatic logic is_burst(input logic [7:0] cmd,
                                    input logic [7:0] addr);
    is_burst = (cmd == `HP_CMD_READ) && (addr == `HP_FIFO_REG);
  endfunction

  assign i2c_mode = cs_s & ~st_reg.dis_i2c; // RULE_01 RULE_03
  assign my_addr = id_s ? `HP_I2C_ADDR_ID1 : `HP_I2C_ADDR_ID0; // RULE_02
  assign s_byte = {st_reg.s_sr[6:0], dat_s};
  assign i_byte = {st_reg.i_sr[6:0], dat_s};
  assign s_cnt_n = st_reg.s_cnt + 6'h01;
  assign s_read = st_reg.s_cmd == `HP_CMD_READ;
  assign s_burst = is_burst(st_reg.s_cmd, st_reg.s_addr);
  assign i_rx = st_reg.i_st inside {HP_I_ADDR, HP_I_REG, HP_I_WDATA};

  always_comb begin
    st_next = st_reg;
    st_next.req.rd = 1'b0;
    st_next.req.wr = 1'b0;
    st_next.pop = 1'b0;

    // Fetched data lands one cycle after the strobe
    if (st_reg.req.rd && !i2c_mode) begin
      st_next.s_out = {i_reg_rdata, 16'h0000}; // RULE_10
    end
    if (st_reg.pop) begin
      st_next.s_out = i_fifo_word; // RULE_14
    end
    if (st_reg.req.rd && i2c_mode) begin
      st_next.i_sr = i_reg_rdata;
      st_next.i_oe = ~i_reg_rdata[7];
    end

    // SPI side
    if (cs_s) begin
      st_next.s_cnt = 6'h00; // RULE_01 RULE_09
      st_next.s_drive = 1'b0;
      st_next.s_done = 1'b0;
      st_next.s_cmd = `HP_CMD_WRITE;
    end else begin
      if (rise && !st_reg.s_done) begin
        st_next.s_sr = s_byte; // RULE_05
        st_next.s_cnt = s_cnt_n;
        if (s_cnt_n == `HP_SPI_ADDR_END) begin
          st_next.s_addr = s_byte; // RULE_06
        end
        if (s_cnt_n == `HP_SPI_FETCH) begin
          st_next.s_cmd = s_byte; // RULE_25
          if (is_burst(s_byte, st_reg.s_addr)) begin
            st_next.pop = 1'b1; // RULE_13
          end else if (s_byte == `HP_CMD_READ) begin
            st_next.req.rd = 1'b1; // RULE_10
            st_next.req.addr = st_reg.s_addr;
          end
        end
        if (s_cnt_n == `HP_SPI_LAST && !s_burst) begin
          st_next.s_done = 1'b1; // RULE_07 RULE_11
          if (st_reg.s_cmd == `HP_CMD_WRITE) begin
            st_next.req.wr = 1'b1; // RULE_07
            st_next.req.addr = st_reg.s_addr;
            st_next.req.wdata = s_byte;
            if (st_reg.s_addr == `HP_DIS_I2C_REG) begin
              st_next.dis_i2c = s_byte[`HP_DIS_I2C_BIT]; // RULE_03
            end
          end
        end
        if (s_cnt_n == `HP_SPI_WORD_END && s_burst) begin
          st_next.s_cnt = `HP_SPI_FETCH; // RULE_13
          st_next.pop = 1'b1;
        end
      end
      if (fall && s_read && st_reg.s_cnt >= `HP_SPI_FETCH) begin
        // Emptied shifter leaves zeros for surplus clocks
        st_next.s_drive = 1'b1; // RULE_04 RULE_11
        st_next.s_sdo = st_reg.s_out[23]; // RULE_05
        st_next.s_out = {st_reg.s_out[22:0], 1'b0};
      end
    end

    // I2C side
    if (!i2c_mode) begin
      st_next.i_st = HP_I_IDLE; // RULE_01
      st_next.i_oe = 1'b0;
      st_next.i_in_start = 1'b0;
    end else if (start) begin
      st_next.i_st = HP_I_ADDR; // RULE_20 RULE_21
      st_next.i_bit = 4'h0;
      st_next.i_oe = 1'b0;
      st_next.i_in_start = 1'b1;
    end else if (stop && !st_reg.i_in_start) begin
      st_next.i_st = HP_I_IDLE; // RULE_20 RULE_22
      st_next.i_oe = 1'b0;
    end else begin
      if (rise) begin
        if (i_rx && st_reg.i_bit <= `HP_I2C_LAST_BIT) begin
          st_next.i_sr = i_byte; // RULE_19
        end
        if (st_reg.i_st == HP_I_RDATA &&
            st_reg.i_bit == `HP_I2C_ACK_BIT) begin
          st_next.i_ack = ~dat_s;
        end
      end
      if (fall && st_reg.i_in_start) begin
        // The fall that closes START carries no data bit
        st_next.i_in_start = 1'b0; // RULE_22
      end else if (fall) begin
        unique case (st_reg.i_st)
          HP_I_IDLE: begin
            st_next.i_oe = 1'b0;
          end
          HP_I_ADDR, HP_I_REG, HP_I_WDATA: begin
            if (st_reg.i_bit < `HP_I2C_LAST_BIT) begin
              st_next.i_bit = st_reg.i_bit + 4'h1; // RULE_16
            end else if (st_reg.i_bit == `HP_I2C_LAST_BIT) begin
              st_next.i_bit = `HP_I2C_ACK_BIT;
              st_next.i_oe = 1'b1; // RULE_23
              if (st_reg.i_st == HP_I_ADDR) begin
                st_next.i_rw = st_reg.i_sr[0];
                if (st_reg.i_sr[7:1] != my_addr[7:1]) begin
                  st_next.i_st = HP_I_IDLE; // RULE_02
                  st_next.i_oe = 1'b0;
                end
              end else if (st_reg.i_st == HP_I_REG) begin
                st_next.i_ptr = st_reg.i_sr;
              end else begin
                st_next.req.wr = 1'b1;
                st_next.req.addr = st_reg.i_ptr;
                st_next.req.wdata = st_reg.i_sr;
                st_next.i_ptr = st_reg.i_ptr + 8'h01; // RULE_17
                if (st_reg.i_ptr == `HP_DIS_I2C_REG) begin
                  st_next.dis_i2c = st_reg.i_sr[`HP_DIS_I2C_BIT];
                end
              end
            end else begin
              st_next.i_bit = 4'h0;
              st_next.i_oe = 1'b0; // RULE_23
              if (st_reg.i_st == HP_I_ADDR && st_reg.i_rw) begin
                st_next.i_st = HP_I_RDATA;
                st_next.req.rd = 1'b1;
                st_next.req.addr = st_reg.i_ptr;
              end else if (st_reg.i_st == HP_I_ADDR) begin
                st_next.i_st = HP_I_REG;
              end else begin
                st_next.i_st = HP_I_WDATA;
              end
            end
          end
          HP_I_RDATA: begin
            if (st_reg.i_bit < `HP_I2C_LAST_BIT) begin
              st_next.i_bit = st_reg.i_bit + 4'h1; // RULE_19
              st_next.i_sr = {st_reg.i_sr[6:0], 1'b0};
              st_next.i_oe = ~st_reg.i_sr[6]; // RULE_18
            end else if (st_reg.i_bit == `HP_I2C_LAST_BIT) begin
              st_next.i_bit = `HP_I2C_ACK_BIT;
              st_next.i_oe = 1'b0;
              st_next.i_ptr = st_reg.i_ptr + 8'h01;
            end else begin
              st_next.i_bit = 4'h0;
              // A refused byte ends the read; STOP is awaited
              if (st_reg.i_ack) begin
                st_next.req.rd = 1'b1;
                st_next.req.addr = st_reg.i_ptr;
              end else begin
                st_next.i_st = HP_I_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.i_st <= HP_I_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sda_out = 1'b0; // RULE_18
  assign o_sda_oe = st_reg.i_oe;
  assign o_sdo = st_reg.s_sdo;
  assign o_sdo_oe = st_reg.s_drive; // RULE_04
  assign o_reg = st_reg.req;
  assign o_fifo_pop = st_reg.pop;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  property p_sdo_off_i2c;
    i2c_mode |=> !o_sdo_oe;
  endproperty
  a_sdo_off_i2c: assert property (p_sdo_off_i2c) // RULE_01
    else $error("SPI output driven in I2C mode");

  property p_addr_nack;
    (i2c_mode && !start && !stop && fall && st_reg.i_st == HP_I_ADDR &&
     st_reg.i_bit == 4'h7 && st_reg.i_sr[7:1] != my_addr[7:1])
    |=> !o_sda_oe && st_reg.i_st == HP_I_IDLE;
  endproperty
  a_addr_nack: assert property (p_addr_nack) // RULE_02
    else $error("Foreign slave address acknowledged");

  property p_sdo_phase;
    o_sdo_oe |-> st_reg.s_cnt >= 6'h10 && s_read;
  endproperty
  a_sdo_phase: assert property (p_sdo_phase) // RULE_04
    else $error("SPI output driven outside read data phase");

  property p_spi_wr_edge;
    (st_reg.i_st == HP_I_IDLE && o_reg.wr)
    |-> st_reg.s_cnt == 6'h18 && st_reg.s_done;
  endproperty
  a_spi_wr_edge: assert property (p_spi_wr_edge) // RULE_07
    else $error("SPI write not on rising edge 24");

  property p_abort;
    cs_s |=> st_reg.s_cnt == 6'h00 && !o_sdo_oe && !st_reg.s_done;
  endproperty
  a_abort: assert property (p_abort) // RULE_09
    else $error("SPI frame not cleared by chip select");

  property p_fetch;
    (!cs_s && rise && !st_reg.s_done && st_reg.s_cnt == 6'h0f &&
     s_byte == 8'h80) |=> (o_reg.rd || o_fifo_pop) ##1 !o_reg.rd;
  endproperty
  a_fetch: assert property (p_fetch) // RULE_10
    else $error("Read fetch missing at edge 16");

  property p_zeros;
    (!cs_s && fall && st_reg.s_done && s_read) |=> !o_sdo;
  endproperty
  a_zeros: assert property (p_zeros) // RULE_11
    else $error("Nonzero bit after edge 24 of a read");

  property p_burst_wrap;
    (!cs_s && rise && s_burst && st_reg.s_cnt == 6'h27)
    |=> o_fifo_pop && st_reg.s_cnt == 6'h10;
  endproperty
  a_burst_wrap: assert property (p_burst_wrap) // RULE_13
    else $error("Burst word boundary missed");

  property p_ptr_step;
    (i2c_mode && o_reg.wr) |-> st_reg.i_ptr == o_reg.addr + 8'h01;
  endproperty
  a_ptr_step: assert property (p_ptr_step) // RULE_17
    else $error("Pointer did not step after data byte");

  property p_ack_hold;
    (i2c_mode && i_rx && st_reg.i_bit == 4'h8 && !start && !stop && rise)
    |-> o_sda_oe ##1 o_sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) // RULE_23
    else $error("Acknowledge not held through ninth clock");

  property p_start;
    (i2c_mode && start) |=> st_reg.i_st == HP_I_ADDR && !o_sda_oe;
  endproperty
  a_start: assert property (p_start) // RULE_20
    else $error("START not taken");

  c_spi_write: cover property (!i2c_mode && o_reg.wr);
  c_burst_pop: cover property (o_fifo_pop ##[1:400] o_fifo_pop);
  c_i2c_write: cover property (i2c_mode && o_reg.wr);
  c_i2c_read: cover property (i2c_mode && o_reg.rd);
endmodule

// ==== hdl/hp_consts.svh ====
// Constants of the dual SPI / I2C host port
`ifndef HP_CONSTS_SVH
`define HP_CONSTS_SVH
`define HP_I2C_ADDR_ID0 8'hd4
`define HP_I2C_ADDR_ID1 8'hd6
`define HP_DIS_I2C_REG 8'h11
`define HP_DIS_I2C_BIT 7
`define HP_CMD_WRITE 8'h00
`define HP_CMD_READ 8'h80
`define HP_FIFO_REG 8'h0c
`define HP_SPI_ADDR_END 6'h08
`define HP_SPI_FETCH 6'h10
`define HP_SPI_LAST 6'h18
`define HP_SPI_WORD_END 6'h28
`define HP_I2C_LAST_BIT 4'h7
`define HP_I2C_ACK_BIT 4'h8
`define HP_SYNC_RST 4'hf
`endif

// ==== hdl/hp_pkg.sv ====
// Types shared by the host port modules
package hp_pkg;
  typedef enum logic [4:0] {
    HP_I_IDLE  = 5'h01,
    HP_I_ADDR  = 5'h02,
    HP_I_REG   = 5'h04,
    HP_I_WDATA = 5'h08,
    HP_I_RDATA = 5'h10
  } hp_i2c_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hp_reg_req_s;

  typedef struct packed {
    logic [3:0] tag;
    logic [19:0] data;
  } hp_fifo_word_s;

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
  } hp_sync_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } hp_cond_s;

  typedef struct packed {
    logic dis_i2c;
    logic [5:0] s_cnt;
    logic [7:0] s_sr;
    logic [7:0] s_addr;
    logic [7:0] s_cmd;
    logic [23:0] s_out;
    logic s_drive;
    logic s_sdo;
    logic s_done;
    logic pop;
    hp_reg_req_s req;
    hp_i2c_e i_st;
    logic [3:0] i_bit;
    logic [7:0] i_sr;
    logic [7:0] i_ptr;
    logic i_rw;
    logic i_ack;
    logic i_oe;
    logic i_in_start;
  } hp_state_s;
endpackage

// ==== hdl/hp_sync.sv ====
// Two-stage synchroniser for the serial pins
module hp_sync import hp_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_async,
  output logic [3:0] o_sync
);
`include "hp_consts.svh"
  hp_sync_s st_reg;
  hp_sync_s st_next;

  always_comb begin
    st_next.meta = i_async;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= {`HP_SYNC_RST, `HP_SYNC_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.sync;
endmodule

// ==== hdl/hp_bus_cond.sv ====
// Clock edge and START / STOP detection on synchronised lines
module hp_bus_cond import hp_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_rise,
  output logic o_fall,
  output logic o_start,
  output logic o_stop
);
  hp_cond_s st_reg;
  hp_cond_s st_next;

  always_comb begin
    st_next.scl = i_scl;
    st_next.sda = i_sda;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= 2'b11;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rise = i_scl & ~st_reg.scl;
  assign o_fall = ~i_scl & st_reg.scl;
  // Data moving while the clock stays high is a bus condition
  assign o_start = i_scl & st_reg.scl & st_reg.sda & ~i_sda;
  assign o_stop = i_scl & st_reg.scl & ~st_reg.sda & i_sda;
endmodule

// ==== bench/hp_host.sv ====
// Host controller model driving the shared serial pins
module hp_host (
  input wire logic i_clk,
  input wire logic i_sdo_line,
  input wire logic i_sda_line,
  output logic o_cs,
  output logic o_sclk,
  output logic o_sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 5;
  initial begin
    o_cs = 1'b1;
    o_sclk = 1'b1;
    o_sdi = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Clock idles high; shift on fall, sample on rise
  task automatic spi_xfer(input int n, input logic [63:0] tx,
                          output logic [63:0] rx);
    rx = '0;
    o_cs = 1'b0;
    wt(Q);
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_sdi = tx[i];
      wt(Q);
      o_sclk = 1'b1;
      rx = {rx[62:0], i_sdo_line};
      wt(Q);
    end
    // Flip the idle level so a stale bit is never mistaken for data
    o_sdi = ~o_sdi;
    wt(2);
    o_cs = 1'b1;
    wt(2 * Q);
  endtask
  task automatic i2c_start();
    o_sdi = 1'b1;
    wt(Q);
    o_sclk = 1'b1;
    wt(Q);
    o_sdi = 1'b0;
    wt(Q);
    o_sclk = 1'b0;
    wt(Q);
  endtask
  task automatic i2c_stop();
    o_sdi = 1'b0;
    wt(Q);
    o_sclk = 1'b1;
    wt(Q);
    o_sdi = 1'b1;
    wt(Q);
  endtask
  // Nine clocks; a bit reads low only if low at both ends of the high phase
  task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] seen);
    logic hi;
    for (int i = 8; i >= 0; i--) begin
      o_sdi = tx[i];
      wt(Q);
      o_sclk = 1'b1;
      hi = i_sda_line;
      wt(2 * Q);
      seen[i] = hi | i_sda_line;
      o_sclk = 1'b0;
      wt(Q);
    end
  endtask
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the dual serial host port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hp_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic id_pin = 1'b0;
  logic cs, sclk, sdi, sda_out, sda_oe, sdo, sdo_oe, pop;
  logic [7:0] rdata;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [31:0] seed = 32'h11;
  logic [63:0] oe_hist = '0;
  hp_reg_req_s req;
  hp_fifo_word_s fifo_word;
  int err_total = 0;
  int checks_done = 0;
  int wr_cnt = 0;
  int pop_cnt = 0;
  // Pull-ups on both data pins
  wire sdo_line = sdo_oe ? sdo : 1'b1;
  wire sda_line = sdi & ~sda_oe;

  function automatic hp_fifo_word_s mk_word(input int k);
    return {4'(k + 32'h3), 20'(k * 32'hbc8f + 32'h4d2)};
  endfunction
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  assign rdata = req.addr ^ 8'h5a;
  assign fifo_word = mk_word(pop_cnt);

  hp_host_port hp_host_port_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_chip_select_low(cs),
    .i_sclk(sclk), .i_sdi_sda(sda_line), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .i_sdo_addr(id_pin), .o_sdo(sdo),
    .o_sdo_oe(sdo_oe), .o_reg(req), .i_reg_rdata(rdata),
    .o_fifo_pop(pop), .i_fifo_word(fifo_word)
  );
  hp_host hp_host_inst (
    .i_clk(i_sys_clk), .i_sdo_line(sdo_line), .i_sda_line(sda_line),
    .o_cs(cs), .o_sclk(sclk), .o_sdi(sdi)
  );

  always #4 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    if (req.wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_addr <= req.addr;
      wr_data <= req.wdata;
    end
    if (pop === 1'b1)
      pop_cnt <= pop_cnt + 1;
  end
  always @(posedge sclk) oe_hist = {oe_hist[62:0], sdo_oe};

  task automatic chk(input string what, input logic [63:0] seen,
                     input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Whole run needs about 50 us, an eighth of this span
  initial begin
    #400000;
    err_total++;
    close_out();
  end

  initial begin
    logic [63:0] rx;
    logic [8:0] s;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
    int n0;
    repeat (8) @(negedge i_sys_clk);
    i_rst = 1'b0;
    hp_host_inst.wt(6);
    // Back-to-back writes, the last with surplus clocks
    for (int k = 0; k < 4; k++) begin
      a = rnd();
      a[7:6] = 2'b01;
      d = rnd();
      n0 = wr_cnt;
      hp_host_inst.spi_xfer(k < 3 ? 24 : 32,
        {32'h0, a, 8'h00, d, 8'hff} >> (k < 3 ? 8 : 0), rx);
      chk("write count", wr_cnt - n0, 64'h1);
      chk("write address", wr_addr, a);
      chk("write data", wr_data, d);
      chk("sdo drive in write", oe_hist[31:0], 64'h0);
    end
    // Early chip-select rise, then an unknown command
    for (int k = 0; k < 2; k++) begin
      n0 = wr_cnt;
      hp_host_inst.spi_xfer(23 + k,
        {40'h0, 8'h30, k ? 8'h40 : 8'h00, 8'h77} >> (1 - k), rx);
      chk("refused write", wr_cnt - n0, 64'h0);
    end
    a = rnd();
    a[7:6] = 2'b01;
    n0 = wr_cnt;
    hp_host_inst.spi_xfer(32, {32'h0, a, 8'h80, 16'h0}, rx);
    chk("read data", rx[15:8], a ^ 8'h5a);
    chk("read surplus", rx[7:0], 64'h0);
    chk("sdo drive in read", oe_hist[31:0], 64'hffff);
    chk("sdo idle", sdo_oe, 64'h0);
    chk("read writes nothing", wr_cnt - n0, 64'h0);
    n0 = pop_cnt;
    hp_host_inst.spi_xfer(64, {8'h0c, 8'h80, 48'h0}, rx);
    chk("burst", rx[47:0], {mk_word(n0), mk_word(n0 + 1)});
    for (int id = 0; id < 2; id++) begin
      id_pin = id[0];
      a = rnd();
      a[7:6] = 2'b01;
      d = rnd();
      e = ~d;
      n0 = wr_cnt;
      hp_host_inst.wt(4);
      hp_host_inst.i2c_start();
      hp_host_inst.i2c_byte({8'hd4 | 8'(2 * id), 1'b1}, s);
      chk("address ack", s[0], 64'h0);
      chk("sda drive level", sda_out, 64'h0);
      hp_host_inst.i2c_byte({a, 1'b1}, s);
      chk("pointer ack", s[0], 64'h0);
      hp_host_inst.i2c_byte({d, 1'b1}, s);
      hp_host_inst.i2c_byte({e, 1'b1}, s);
      chk("data ack", s[0], 64'h0);
      chk("i2c write count", wr_cnt - n0, 64'h2);
      chk("i2c write address", wr_addr, a + 8'h1);
      chk("i2c write data", wr_data, e);
      hp_host_inst.i2c_start();
      hp_host_inst.i2c_byte({8'hd5 | 8'(2 * id), 1'b1}, s);
      chk("read address ack", s[0], 64'h0);
      hp_host_inst.i2c_byte(9'h1fe, s);
      chk("i2c read data", s[8:1], (a + 8'h2) ^ 8'h5a);
      hp_host_inst.i2c_byte(9'h1ff, s);
      chk("i2c read next", s[8:1], (a + 8'h3) ^ 8'h5a);
      hp_host_inst.i2c_stop();
      n0 = wr_cnt;
      hp_host_inst.i2c_start();
      hp_host_inst.i2c_byte({8'hd6 ^ 8'(2 * id), 1'b1}, s);
      chk("foreign address", s[0], 64'h1);
      hp_host_inst.i2c_byte({a, 1'b1}, s);
      hp_host_inst.i2c_stop();
      chk("foreign writes nothing", wr_cnt - n0, 64'h0);
    end
    hp_host_inst.spi_xfer(24, {40'h0, 8'h11, 8'h00, 8'h80}, rx);
    hp_host_inst.i2c_start();
    hp_host_inst.i2c_byte({8'hd6, 1'b1}, s);
    chk("ack after disable", s[0], 64'h1);
    hp_host_inst.i2c_stop();
    close_out();
  end
endmodule
